/* File: inc/adc_pkg.sv */
package adc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADC_OFS_MODE      = 8'h00;
  localparam logic [7:0] ADC_OFS_CHSEL     = 8'h04;
  localparam logic [7:0] ADC_OFS_PORTCFG   = 8'h08;
  localparam logic [7:0] ADC_OFS_RESULT    = 8'h0C;
  localparam logic [7:0] ADC_OFS_RESULT_HI = 8'h10;
  localparam logic [7:0] ADC_OFS_STATUS    = 8'h14;
  localparam logic [7:0] ADC_OFS_MASK      = 8'h18;
  localparam logic [7:0] ADC_OFS_PORT      = 8'h1C;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int         ADC_MODE_START_BIT  = 7;
  localparam int         ADC_MODE_CMPEN_BIT  = 0;
  localparam logic [7:0] ADC_MODE_RESET      = 8'h00;
  localparam int         ADC_CH_W            = 3;
  localparam int         ADC_NUM_CH          = 8;
  localparam logic [2:0] ADC_CHSEL_RESET     = 3'h0;
  localparam logic [7:0] ADC_PORTCFG_RESET   = 8'h00;
  localparam int         ADC_RES_BITS        = 10;
  localparam int         ADC_RESULT_VALID_BIT = 31;
  localparam int         ADC_STAT_W          = 2;
  localparam int         ADC_STAT_DONE_BIT   = 0;
  localparam int         ADC_STAT_SUSPECT_BIT = 1;
  localparam logic [1:0] ADC_STAT_RESET      = 2'h0;
  localparam logic [1:0] ADC_MASK_RESET      = 2'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int ADC_CLK_MHZ       = 40;
  localparam int ADC_SETTLE_NS     = 1000;
  localparam int ADC_SETTLE_CYCLES = (ADC_SETTLE_NS * ADC_CLK_MHZ + 999) / 1000;
  localparam int ADC_SAMPLE_CYCLES = 8;

  typedef enum logic [1:0] {
    ADC_IDLE,
    ADC_SAMPLE,
    ADC_CONV
  } adc_sar_state_e;

endpackage

/* File: src/adc_settle_timer.sv */
`timescale 1ns/1ps
module adc_settle_timer
  import adc_pkg::*;
#(
  parameter int SETTLE_CYCLES = ADC_SETTLE_CYCLES
) (
  input  wire logic i_ref_clk,  // clock
  input  wire logic i_rstn,     // async reset, active low
  input  wire logic i_ce,       // clock enable
  input  wire logic i_cmp_en,   // comparator enable bit
  output logic      o_settled   // comparator enabled long enough
);

  generate
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad
      $error("adc_settle_timer: SETTLE_CYCLES out of range");
    end
  endgenerate

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(SETTLE_CYCLES);

  logic [CNT_W-1:0] cnt_reg;

  // restarts whenever the comparator is switched off
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
    end else if (i_ce) begin
      if (!i_cmp_en) begin
        cnt_reg <= '0;
      end else if (cnt_reg != CNT_MAX) begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

  assign o_settled = (cnt_reg == CNT_MAX);

endmodule // adc_settle_timer

/* File: src/adc_sar_engine.sv */
`timescale 1ns/1ps
module adc_sar_engine
  import adc_pkg::*;
#(
  parameter int RES_BITS      = ADC_RES_BITS,
  parameter int SAMPLE_CYCLES = ADC_SAMPLE_CYCLES
) (
  input  wire logic                i_ref_clk,  // clock
  input  wire logic                i_rstn,     // async reset, active low
  input  wire logic                i_ce,       // clock enable
  input  wire logic                i_run,      // convert continuously while high
  input  wire logic                i_restart,  // abort and begin a fresh sample
  input  wire logic                i_cmp,      // comparator: input above trial code
  output logic                     o_sample,   // sampling switch closed
  output logic [RES_BITS-1:0]      o_dac_code, // trial code to the dac
  output logic                     o_done,     // one-cycle pulse, result valid
  output logic [RES_BITS-1:0]      o_result    // last finished code
);

  generate
    if (RES_BITS < 2 || RES_BITS > 16 || SAMPLE_CYCLES < 1) begin : g_bad
      $error("adc_sar_engine: unsupported parameters");
    end
  endgenerate

  localparam int BI_W = $clog2(RES_BITS);
  localparam int SC_W = $clog2(SAMPLE_CYCLES + 1);
  localparam logic [BI_W-1:0] BI_MSB  = BI_W'(RES_BITS - 1);
  localparam logic [SC_W-1:0] SC_LAST = SC_W'(SAMPLE_CYCLES - 1);

  adc_sar_state_e        state_reg;
  logic [SC_W-1:0]       scnt_reg;
  logic [BI_W-1:0]       bit_reg;
  logic [RES_BITS-1:0]   code_reg;
  logic                  last_bit;

  assign last_bit = (state_reg == ADC_CONV) && (bit_reg == '0);

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ADC_IDLE;
      scnt_reg  <= '0;
      bit_reg   <= '0;
      code_reg  <= '0;
    end else if (i_ce) begin
      if (!i_run) begin
        state_reg <= ADC_IDLE;
        code_reg  <= '0;
      end else if (i_restart) begin
        state_reg <= ADC_SAMPLE;
        scnt_reg  <= '0;
        code_reg  <= '0;
      end else begin
        unique case (state_reg)
          ADC_IDLE: begin
            state_reg <= ADC_SAMPLE;
            scnt_reg  <= '0;
          end
          ADC_SAMPLE: begin
            scnt_reg <= scnt_reg + SC_W'(1);
            if (scnt_reg == SC_LAST) begin
              state_reg         <= ADC_CONV;
              bit_reg           <= BI_MSB;
              code_reg          <= '0;
              code_reg[BI_MSB]  <= 1'b1;
            end
          end
          ADC_CONV: begin
            code_reg[bit_reg] <= i_cmp;
            if (bit_reg != '0) begin
              code_reg[bit_reg - BI_W'(1)] <= 1'b1;
              bit_reg                      <= bit_reg - BI_W'(1);
            end else begin
              // continuous: next sample follows at once
              state_reg <= ADC_SAMPLE;
              scnt_reg  <= '0;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // result capture
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_done   <= 1'b0;
      o_result <= '0;
    end else if (i_ce) begin
      o_done <= last_bit && i_run && !i_restart;
      if (last_bit && i_run && !i_restart) begin
        o_result          <= code_reg;
        o_result[bit_reg] <= i_cmp;
      end
    end
  end

  assign o_sample   = (state_reg == ADC_SAMPLE);
  assign o_dac_code = code_reg;

endmodule // adc_sar_engine

/* File: src/adc_ctl_top.sv */
`timescale 1ns/1ps
// Function
// RULE_01: analog lines double as eight digital inputs
// RULE_02: software leaves port bits alone while converting
// RULE_03: channel rewrite never clears the done flag
// RULE_04: old-channel result may land before rewrite
// RULE_05: done after channel change may be stale
// RULE_06: clear done flag before restarting conversion
// RULE_07: start within 1 us of enable: suspect
// RULE_08: start with comparator disabled: first result suspect
// RULE_09: software drops first result after start
// RULE_10: config writes leave results undefined
// RULE_11: read result before writing configuration
// RULE_12: mode bit 7 start, bit 0 enable
module adc_ctl_top
  import adc_pkg::*;
#(
  parameter int SETTLE_CYCLES = ADC_SETTLE_CYCLES,
  parameter int SAMPLE_CYCLES = ADC_SAMPLE_CYCLES
) (
  input  wire logic                    i_ref_clk,   // 40 MHz clock
  input  wire logic                    i_rstn,      // async reset, active low
  input  wire logic                    i_ce,        // clock enable, freezes all state
  input  wire logic                    i_psel,      // apb select
  input  wire logic                    i_penable,   // apb access phase
  input  wire logic                    i_pwrite,    // apb direction
  input  wire logic [7:0]              i_paddr,     // apb byte address
  input  wire logic [31:0]             i_pwdata,    // apb write data
  output logic      [31:0]             o_prdata,    // apb read data
  output logic                         o_pready,    // apb ready
  output logic                         o_pslverr,   // apb error, unmapped address
  input  wire logic                    i_cmp,       // analog comparator output
  output logic                         o_sample,    // sample switch
  output logic      [ADC_RES_BITS-1:0] o_dac_code,  // sar trial code
  output logic      [ADC_CH_W-1:0]     o_ch_sel,    // analog mux select
  output logic                         o_cmp_en,    // comparator power
  output logic      [ADC_NUM_CH-1:0]   o_analog_en, // per line analog mode
  input  wire logic [ADC_NUM_CH-1:0]   i_port_pins, // digital level of the lines
  output logic                         o_irq        // conversion end interrupt
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]              mode_reg;
  logic [ADC_CH_W-1:0]     chsel_reg;
  logic [ADC_NUM_CH-1:0]   portcfg_reg;
  logic [ADC_RES_BITS-1:0] result_reg;
  logic                    result_valid_reg;
  logic [ADC_STAT_W-1:0]   status_reg;
  logic [ADC_STAT_W-1:0]   mask_reg;
  logic [ADC_STAT_W-1:0]   rd_clr_reg;
  logic                    first_pending_reg;
  logic                    first_suspect_reg;

  logic                    setup_ph;
  logic                    access_ph;
  logic                    wr_en;
  logic                    rd_en;
  logic                    addr_hit;
  logic                    wr_mode;
  logic                    wr_chsel;
  logic                    wr_portcfg;
  logic                    cfg_wr;
  logic                    start_bit;
  logic                    cmpen_bit;
  logic                    start_rise;
  logic                    settled;
  logic                    eng_done;
  logic [ADC_RES_BITS-1:0] eng_result;
  logic                    store_ok;
  logic [ADC_STAT_W-1:0]   stat_set;
  logic [31:0]             rd_mux;
  logic [ADC_NUM_CH-1:0]   port_view;

  // ****************************************
  // parameter checks
  // ****************************************
  generate
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535 || SAMPLE_CYCLES < 1) begin : g_bad
      $error("adc_ctl_top: unsupported parameters");
    end
  endgenerate

  // ****************************************
  // apb decode
  // ****************************************
  // zero wait states: read data captured in setup, effects at access edge
  // status is the only register with a read side effect
  // pslverr needs no flop: the address is held through access
  assign setup_ph  = i_psel && !i_penable;
  assign access_ph = i_psel && i_penable;
  assign o_pready  = access_ph;

  always_comb begin
    unique case (i_paddr)
      ADC_OFS_MODE, ADC_OFS_CHSEL, ADC_OFS_PORTCFG, ADC_OFS_RESULT,
      ADC_OFS_RESULT_HI, ADC_OFS_STATUS, ADC_OFS_MASK, ADC_OFS_PORT: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign o_pslverr  = access_ph && !addr_hit;
  assign wr_en      = access_ph && i_pwrite && addr_hit;
  assign rd_en      = access_ph && !i_pwrite && addr_hit;
  assign wr_mode    = wr_en && (i_paddr == ADC_OFS_MODE);
  assign wr_chsel   = wr_en && (i_paddr == ADC_OFS_CHSEL);
  assign wr_portcfg = wr_en && (i_paddr == ADC_OFS_PORTCFG);
  assign cfg_wr     = wr_mode || wr_chsel || wr_portcfg;

  assign start_bit  = mode_reg[ADC_MODE_START_BIT]; // RULE_12
  assign cmpen_bit  = mode_reg[ADC_MODE_CMPEN_BIT]; // RULE_12
  assign start_rise = wr_mode && i_pwdata[ADC_MODE_START_BIT] && !start_bit;

  // ****************************************
  // configuration registers
  // ****************************************
  // mask writes leave the conversion in flight alone
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_reg    <= ADC_MODE_RESET;
      chsel_reg   <= ADC_CHSEL_RESET;
      portcfg_reg <= ADC_PORTCFG_RESET;
      mask_reg    <= ADC_MASK_RESET;
    end else if (i_ce) begin
      if (wr_mode) begin
        mode_reg <= i_pwdata[7:0]; // RULE_12
      end
      if (wr_chsel) begin
        chsel_reg <= i_pwdata[ADC_CH_W-1:0];
      end
      if (wr_portcfg) begin
        portcfg_reg <= i_pwdata[ADC_NUM_CH-1:0];
      end
      if (wr_en && i_paddr == ADC_OFS_MASK) begin
        mask_reg <= i_pwdata[ADC_STAT_W-1:0];
      end
    end
  end

  // ****************************************
  // conversion engine and settle timer
  // ****************************************
  adc_settle_timer #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_cmp_en  (cmpen_bit),
    .o_settled (settled)
  );

  // any config write aborts the sample in flight, so a new channel
  // never inherits half a conversion of the old one
  adc_sar_engine #(
    .RES_BITS      (ADC_RES_BITS),
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_sar (
    .i_ref_clk  (i_ref_clk),
    .i_rstn     (i_rstn),
    .i_ce       (i_ce),
    .i_run      (start_bit),
    .i_restart  (cfg_wr),
    .i_cmp      (i_cmp),
    .o_sample   (o_sample),
    .o_dac_code (o_dac_code),
    .o_done     (eng_done),
    .o_result   (eng_result)
  );

  // config write in the same cycle wins: no store, no event
  assign store_ok = eng_done && !cfg_wr; // RULE_04

  // ****************************************
  // result register
  // ****************************************
  // undefined contents shown as a cleared valid bit;
  // the stale code stays readable for debug
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      result_reg       <= '0;
      result_valid_reg <= 1'b0;
    end else if (i_ce) begin
      if (cfg_wr) begin
        result_valid_reg <= 1'b0; // RULE_10
      end else if (store_ok) begin
        result_reg       <= eng_result; // RULE_04
        result_valid_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // first result qualification
  // ****************************************
  // suspect if start lands before the comparator has settled or while off
  // the mark only tags the result; software still decides
  // which result to drop
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      first_pending_reg <= 1'b0;
      first_suspect_reg <= 1'b0;
    end else if (i_ce) begin
      if (start_rise) begin
        first_pending_reg <= 1'b1;
        first_suspect_reg <= !(cmpen_bit && settled) // RULE_07
                             || !i_pwdata[ADC_MODE_CMPEN_BIT]; // RULE_08
      end else if (store_ok) begin
        first_pending_reg <= 1'b0;
        first_suspect_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // status, mask and interrupt
  // ****************************************
  always_comb begin
    stat_set                       = '0;
    stat_set[ADC_STAT_DONE_BIT]    = store_ok;
    stat_set[ADC_STAT_SUSPECT_BIT] = store_ok && first_pending_reg && first_suspect_reg;
  end

  // channel writes do not touch it; only a status read clears,
  // and only bits that read actually returned, set winning
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_reg <= ADC_STAT_RESET;
    end else if (i_ce) begin
      if (rd_en && i_paddr == ADC_OFS_STATUS) begin
        status_reg <= (status_reg & ~rd_clr_reg) | stat_set; // RULE_03
      end else begin
        status_reg <= status_reg | stat_set; // RULE_03
      end
    end
  end

  // registered so the pin never glitches on address decode;
  // costs one cycle of interrupt latency
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(status_reg & mask_reg);
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rd_mux = '0;
    unique case (i_paddr)
      ADC_OFS_MODE:      rd_mux[7:0] = mode_reg;
      ADC_OFS_CHSEL:     rd_mux[ADC_CH_W-1:0] = chsel_reg;
      ADC_OFS_PORTCFG:   rd_mux[ADC_NUM_CH-1:0] = portcfg_reg;
      ADC_OFS_RESULT: begin
        rd_mux[ADC_RES_BITS-1:0]     = result_reg;
        rd_mux[ADC_RESULT_VALID_BIT] = result_valid_reg;
      end
      ADC_OFS_RESULT_HI: rd_mux[7:0] = result_reg[ADC_RES_BITS-1:ADC_RES_BITS-8];
      ADC_OFS_STATUS:    rd_mux[ADC_STAT_W-1:0] = status_reg;
      ADC_OFS_MASK:      rd_mux[ADC_STAT_W-1:0] = mask_reg;
      // analog-mode lines read as zero on the port
      ADC_OFS_PORT:      rd_mux[ADC_NUM_CH-1:0] = port_view; // RULE_01
      default:           rd_mux = '0;
    endcase
  end

  // captured in setup so the access edge sees a settled word
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata   <= '0;
      rd_clr_reg <= '0;
    end else if (i_ce) begin
      if (setup_ph && !i_pwrite) begin
        o_prdata   <= rd_mux;
        rd_clr_reg <= (i_paddr == ADC_OFS_STATUS) ? status_reg : '0;
      end
    end
  end

  // ****************************************
  // analog front end controls
  // ****************************************
  // mux select follows the register at the write edge; the abort
  // above keeps the old sample out of the new channel
  assign o_ch_sel    = chsel_reg;
  assign o_cmp_en    = cmpen_bit;

  // ****************************************
  // shared lines, one slice per channel
  // ****************************************
  // a line in analog use reads as zero, so software never sees
  // its digital level change during a conversion
  generate
    for (genvar gi = 0; gi < ADC_NUM_CH; gi++) begin : g_line
      assign port_view[gi]   = i_port_pins[gi] && portcfg_reg[gi]; // RULE_01
      assign o_analog_en[gi] = !portcfg_reg[gi]; // RULE_01
    end
  endgenerate

endmodule // adc_ctl_top

/* File: tb/adc_ctl_checker.sv */
`timescale 1ns/1ps
module adc_ctl_checker
  import adc_pkg::*;
(
  input wire logic        i_ref_clk,   // clock
  input wire logic        i_rstn,      // async reset, active low
  input wire logic        i_ce,        // clock enable
  input wire logic        i_psel,      // apb select
  input wire logic        i_penable,   // apb access
  input wire logic        i_pwrite,    // apb direction
  input wire logic [7:0]  i_paddr,     // apb address
  input wire logic [31:0] i_pwdata,    // apb write data
  input wire logic [31:0] o_prdata,    // apb read data
  input wire logic        o_pslverr,   // apb error
  input wire logic        o_sample,    // sample switch
  input wire logic [2:0]  o_ch_sel,    // mux select
  input wire logic        o_cmp_en,    // comparator power
  input wire logic [7:0]  o_analog_en, // analog mode per line
  input wire logic [7:0]  i_port_pins  // pin levels
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  logic wr_acc;
  assign wr_acc = i_psel && i_penable && i_pwrite && i_ce;

  a_cmp_en_mode: assert property (wr_acc && i_paddr == ADC_OFS_MODE |=>
    o_cmp_en == $past(i_pwdata[ADC_MODE_CMPEN_BIT])) else $error("comparator enable wrong");
  a_start_samples: assert property (wr_acc && i_paddr == ADC_OFS_MODE
    && i_pwdata[ADC_MODE_START_BIT] |-> ##2 o_sample) else $error("start did not sample");
  a_stop_idle: assert property (wr_acc && i_paddr == ADC_OFS_MODE
    && !i_pwdata[ADC_MODE_START_BIT] |-> ##2 !o_sample) else $error("stop still sampling");
  a_chsel_write: assert property (wr_acc && i_paddr == ADC_OFS_CHSEL |=>
    o_ch_sel == $past(i_pwdata[2:0])) else $error("channel write lost");
  a_chsel_hold: assert property (!(wr_acc && i_paddr == ADC_OFS_CHSEL) |=>
    $stable(o_ch_sel)) else $error("channel changed without write");
  a_cfg_write: assert property (wr_acc && i_paddr == ADC_OFS_PORTCFG |=>
    o_analog_en == ~$past(i_pwdata[7:0])) else $error("port config write lost");
  a_port_read: assert property (i_psel && !i_penable && !i_pwrite && i_ce
    && i_paddr == ADC_OFS_PORT |=> o_prdata == {24'h0, $past(i_port_pins & ~o_analog_en)})
    else $error("port read wrong");
  a_map_error: assert property (i_psel && i_penable
    && (i_paddr[1:0] != 2'h0 || i_paddr > ADC_OFS_PORT) |-> o_pslverr)
    else $error("unmapped access not refused");
endmodule // adc_ctl_checker

bind adc_ctl_top adc_ctl_checker adc_ctl_checker_i (.i_ref_clk, .i_rstn, .i_ce, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pslverr, .o_sample, .o_ch_sel,
  .o_cmp_en, .o_analog_en, .i_port_pins);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import adc_pkg::*;
  localparam int SETTLE = 4;
  logic                    i_ref_clk, i_rstn, i_ce, i_psel, i_penable, i_pwrite, i_cmp;
  logic [7:0]              i_paddr, i_port_pins, cfg, pins;
  logic [31:0]             i_pwdata, o_prdata, rd;
  logic                    o_pready, o_pslverr, o_sample, o_cmp_en, o_irq, err;
  logic [ADC_RES_BITS-1:0] o_dac_code, target;
  logic [ADC_CH_W-1:0]     o_ch_sel, ch;
  logic [ADC_NUM_CH-1:0]   o_analog_en;
  int                      num_errors, checked, n;
  logic [7:0]              pre[3] = '{8'h00, 8'h01, 8'h01};
  logic [7:0]              st[3] = '{8'h80, 8'h81, 8'h81};
  int                      gap[3] = '{0, 0, 2 * SETTLE};
  logic                    sus[3] = '{1'b1, 1'b1, 1'b0};

  // analog level sits half a code above target, so the sar lands on target exactly
  assign i_cmp = (o_dac_code <= target);

  adc_ctl_top #(.SETTLE_CYCLES(SETTLE), .SAMPLE_CYCLES(ADC_SAMPLE_CYCLES)) adc_ctl_top_i (
    .i_ref_clk, .i_rstn, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_cmp, .o_sample, .o_dac_code, .o_ch_sel, .o_cmp_en,
    .o_analog_en, .i_port_pins, .o_irq);

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    // no local limit: only the watchdog ends a stalled transfer
    do begin
      @(posedge i_ref_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // bounded: a lost interrupt ends the run as a failure after 200 cycles, not a hang
  task wait_irq();
    n = 0;
    while (o_irq !== 1'b1 && n < 200) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      conclude();
    end
  endtask

  task conclude();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #500000;
    num_errors++;
    conclude();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    i_rstn = 1'b0;
    i_ce = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_port_pins = 8'h00;
    target = 10'h000;
    num_errors = 0;
    checked = 0;
    n = $urandom(32'h54A8);
    repeat (2) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    chk("analog_en_reset", o_analog_en, 8'hFF);
    for (int a = 0; a <= 8'h1C; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      chk("reset_value", rd, 32'h0);
    end
    apb(1'b0, 8'h22, 32'h0);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    $display("test reset done");
    apb(1'b1, ADC_OFS_MASK, 32'h3);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADC_OFS_MODE, 32'h0);
      apb(1'b0, ADC_OFS_STATUS, 32'h0);
      apb(1'b1, ADC_OFS_MODE, {24'h0, pre[i]});
      repeat (gap[i]) @(posedge i_ref_clk);
      target <= (i == 1) ? 10'h3FF : 10'($urandom);
      apb(1'b1, ADC_OFS_MODE, {24'h0, st[i]});
      wait_irq();
      chk("irq_latency", n, ADC_SAMPLE_CYCLES + ADC_RES_BITS + 3);
      apb(1'b0, ADC_OFS_STATUS, 32'h0);
      chk("status", rd, {30'h0, sus[i], 1'b1});
      apb(1'b0, ADC_OFS_RESULT, 32'h0);
      chk("result", rd, {1'b1, 21'h0, target});
      apb(1'b0, ADC_OFS_RESULT_HI, 32'h0);
      chk("result_hi", rd, {24'h0, target[9:2]});
      apb(1'b0, ADC_OFS_STATUS, 32'h0);
      chk("status_clear", rd, 32'h0);
      @(posedge i_ref_clk);
      #1;
      chk("irq_clear", o_irq, 1'b0);
    end
    $display("test start-up done");
    wait_irq();
    ch = 3'($urandom);
    apb(1'b1, ADC_OFS_CHSEL, {29'h0, ch});
    apb(1'b0, ADC_OFS_STATUS, 32'h0);
    chk("done_kept", rd, 32'h1);
    chk("ch_sel", o_ch_sel, ch);
    apb(1'b0, ADC_OFS_RESULT, 32'h0);
    chk("result_void", rd[ADC_RESULT_VALID_BIT], 1'b0);
    $display("test channel done");
    apb(1'b1, ADC_OFS_MASK, 32'h0);
    repeat (30) @(posedge i_ref_clk);
    #1;
    chk("irq_masked", o_irq, 1'b0);
    apb(1'b0, ADC_OFS_STATUS, 32'h0);
    chk("status_masked", rd[ADC_STAT_DONE_BIT], 1'b1);
    $display("test mask done");
    apb(1'b1, ADC_OFS_MODE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      cfg = (i == 0) ? 8'hFF : 8'($urandom);
      pins = (i == 0) ? 8'hFF : 8'($urandom);
      i_port_pins <= pins;
      apb(1'b1, ADC_OFS_PORTCFG, {24'h0, cfg});
      apb(1'b0, ADC_OFS_PORT, 32'h0);
      chk("port", rd, {24'h0, pins & cfg});
      chk("analog_en", o_analog_en, 8'(~cfg));
    end
    $display("test port done");
    i_ce <= 1'b0;
    apb(1'b1, ADC_OFS_MASK, 32'h3);
    i_ce <= 1'b1;
    apb(1'b0, ADC_OFS_MASK, 32'h0);
    chk("ce_freeze", rd, 32'h0);
    $display("test clock enable done");
    conclude();
  end
endmodule // tb_top
